// *** design/autozero_pkg.sv ***
package autozero_pkg;
  // serial frame edges, counted as falling serial clock edges from 1
  localparam logic [5:0] MUX_EDGE = 6'h0d;
  localparam logic [5:0] START_EDGE = 6'h20;
  localparam logic [4:0] CFG_BITS = 5'h0d;
  // channel, mode and ratio fields of the configuration word
  localparam int CH_W = 3;
  localparam int CH_POS = 0;
  localparam int MODE_POS = 3;
  localparam int OSR_POS = 4;
  localparam int OSR_W = 4;
  // modulator cycles per half-conversion for the smallest ratio
  localparam logic [23:0] HALF_BASE = 24'h00_0040;
  localparam int DATA_W = 24;
  // clock and settle time
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SETTLE_US = 50;
  localparam int SETTLE_CYCLES =
    (SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // reset values
  localparam logic [CH_W-1:0] CH_RESET = 3'h0;
  localparam logic [23:0] ZERO24 = 24'h00_0000;
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b00_0001,
    ST_FRAME  = 6'b00_0010,
    ST_HALF1  = 6'b00_0100,
    ST_SETTLE = 6'b00_1000,
    ST_HALF2  = 6'b01_0000,
    ST_DONE   = 6'b10_0000
  } state_t;
endpackage : autozero_pkg

// *** design/autozero_mux_sequencer.sv ***
`timescale 1ns/1ps
module autozero_mux_sequencer
  import autozero_pkg::*;
#(
  parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic mod_bit,
  output logic [CH_W-1:0] buffer_a_input,
  output logic [CH_W-1:0] buffer_b_input,
  output logic converting,
  output logic half_done,
  output logic result_valid,
  output logic [DATA_W-1:0] result,
  output logic busy
);
  // *************************************************************
  // overview
  // *************************************************************
  // the serial pins come from the host's clock domain, so each one
  // runs through at least two flip-flops before any logic looks at it.
  // a falling serial clock edge is found between stages two and
  // three, and the data bit taken with it is read from stage three,
  // so the bit and the edge are always seen as one pair.
  //
  // the frame counter counts falling edges from one. the first
  // thirteen bits form the configuration word, msb first; the
  // thirteenth bit is merged into the word in the same cycle in
  // which the mux is set, so the channel field is never one bit
  // short.
  //
  // the conversion proper starts at edge thirty-two. that leaves the
  // gap after the channel switch for the buffers to slew, which is
  // the whole point of switching early.
  //
  // each half-conversion takes one modulator bit per cycle into a
  // signed accumulator. the result is first half minus second half,
  // and since the pair is reversed between the halves, any offset
  // that both halves share drops out of the result.
  //
  // limitation: the modulator itself is outside this block; we only
  // see its bit stream, so a stuck stream gives a zero result.
  //
  // in 2x mode an idle settle span sits between the halves. it costs
  // output rate but keeps slew out of the second half. the span is
  // a parameter so a bench can shorten it.
  //
  // after the second half the pair is reversed once more, back to
  // the forward polarity of the same channel, on the guess that the
  // next frame converts that channel again. a frame that names
  // another channel then moves the mux at edge thirteen.
  //
  // a frame cut short before edge thirty-two starts nothing and
  // leaves the mux where it stands.

  // *************************************************************
  // state
  // *************************************************************
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [2:0] sdi_s;
    logic [2:0] mod_s;
    state_t st;
    logic [5:0] edge_cnt;
    logic [12:0] shift;
    logic [CH_W-1:0] sel_ch;
    logic two_x;
    logic [OSR_W-1:0] oversample_ratio;
    logic [CH_W-1:0] cur_ch;
    logic [CH_W-1:0] ina;
    logic [CH_W-1:0] inb;
    logic [23:0] half_cnt;
    logic [23:0] settle_cnt;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] first_half;
    logic [DATA_W-1:0] res;
    logic res_v;
    logic hdone;
  } state_s_t;

  state_s_t r;
  state_s_t next_r;

  logic fall;
  logic sdi_lvl;
  logic [12:0] word;
  logic frame_on;
  logic [23:0] half_len;
  logic [DATA_W-1:0] step;

  // *************************************************************
  // combinational next state
  // *************************************************************
  always_comb begin
    next_r = r;
    next_r.res_v = 1'b0;
    next_r.hdone = 1'b0;
    // three-stage sync, level read from stage three, falling edge where stage three is high and stage two low
    next_r.sclk_s = {r.sclk_s[1:0], sclk};
    next_r.cs_s = {r.cs_s[1:0], cs_n};
    next_r.sdi_s = {r.sdi_s[1:0], sdi};
    next_r.mod_s = {r.mod_s[1:0], mod_bit};
    fall = (r.sclk_s[2] & ~r.sclk_s[1]);
    sdi_lvl = r.sdi_s[2];
    // word including the bit taken on this edge
    word = {r.shift[11:0], sdi_lvl};
    frame_on = ~r.cs_s[2];
    half_len = HALF_BASE << r.oversample_ratio;
    // modulator bit weighs +1/-1 on the accumulator
    step = r.mod_s[2] ? 24'h00_0001 : 24'hff_ffff;
    unique case (r.st)
      ST_IDLE, ST_DONE: begin
        if (frame_on) begin
          next_r.st = ST_FRAME;
          next_r.edge_cnt = 6'h00;
        end
      end
      ST_FRAME: begin
        if (!frame_on) begin
          // aborted frame leaves the mux as it stands
          next_r.st = ST_IDLE;
        end else if (fall) begin
          next_r.edge_cnt = r.edge_cnt + 6'h01;
          if (r.edge_cnt < {1'b0, CFG_BITS}) begin
            next_r.shift = word;
          end
          if (r.edge_cnt + 6'h01 == MUX_EDGE) begin
            // word is complete here, apply pair unless already applied
            next_r.sel_ch = word[CH_POS +: CH_W];
            next_r.two_x = word[MODE_POS];
            next_r.oversample_ratio = word[OSR_POS +: OSR_W];
            if (word[CH_POS +: CH_W] != r.cur_ch ||
                r.ina != r.cur_ch) begin
              next_r.ina = word[CH_POS +: CH_W];
              next_r.inb = word[CH_POS +: CH_W] ^ 3'h1;
            end
            next_r.cur_ch = word[CH_POS +: CH_W];
          end
          if (r.edge_cnt + 6'h01 == START_EDGE) begin
            next_r.st = ST_HALF1;
            next_r.half_cnt = ZERO24;
            next_r.acc = ZERO24;
          end
        end
      end
      ST_HALF1: begin
        next_r.acc = r.acc + step;
        next_r.half_cnt = r.half_cnt + 24'h00_0001;
        if (r.half_cnt + 24'h00_0001 == half_len) begin
          // midpoint: reverse the pair
          next_r.ina = r.inb;
          next_r.inb = r.ina;
          next_r.first_half = r.acc + step;
          next_r.hdone = 1'b1;
          next_r.half_cnt = ZERO24;
          next_r.acc = ZERO24;
          next_r.settle_cnt = ZERO24;
          next_r.st = r.two_x ? ST_SETTLE : ST_HALF2;
        end
      end
      ST_SETTLE: begin
        // buffers settle before the second half in 2x mode
        next_r.settle_cnt = r.settle_cnt + 24'h00_0001;
        if (r.settle_cnt + 24'h00_0001 >= SETTLE_COUNT[23:0]) begin
          next_r.st = ST_HALF2;
        end
      end
      ST_HALF2: begin
        next_r.acc = r.acc + step;
        next_r.half_cnt = r.half_cnt + 24'h00_0001;
        if (r.half_cnt + 24'h00_0001 == half_len) begin
          next_r.res = r.first_half - (r.acc + step);
          next_r.res_v = 1'b1;
          // back to the forward polarity, same channel
          next_r.ina = r.inb;
          next_r.inb = r.ina;
          next_r.st = ST_DONE;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
  end

  // *************************************************************
  // registers
  // *************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.sclk_s <= 3'h0;
      r.cs_s <= 3'h7;
      r.st <= ST_IDLE;
      r.cur_ch <= CH_RESET;
      r.ina <= CH_RESET;
      r.inb <= CH_RESET ^ 3'h1;
    end else begin
      r <= next_r;
    end
  end

  // *************************************************************
  // outputs, straight from flip-flops except converting and busy, which OR state bits
  // *************************************************************
  assign buffer_a_input = r.ina;
  assign buffer_b_input = r.inb;
  assign converting = r.st[2] | r.st[4];
  assign half_done = r.hdone;
  assign result_valid = r.res_v;
  assign result = r.res;
  assign busy = r.st[2] | r.st[3] | r.st[4];
endmodule : autozero_mux_sequencer

// *** verif/azm_chk.sv ***
`timescale 1ns/1ps
module azm_chk
  import autozero_pkg::*;
#(
  parameter int SETTLE_COUNT = 10
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [CH_W-1:0] buffer_a_input,
  input wire logic [CH_W-1:0] buffer_b_input,
  input wire logic converting,
  input wire logic half_done,
  input wire logic result_valid,
  input wire logic [DATA_W-1:0] result,
  input wire logic busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  int gap;
  // idle cycles between halves; only 2x mode ever has any
  always_ff @(posedge ref_clk) gap <= (busy && !converting) ? gap + 1 : 0;
  property p_pair; buffer_b_input == (buffer_a_input ^ 3'h1); endproperty
  a_pair: assert property (p_pair) else $error("pair");
  property p_mid; half_done |-> ##[0:2] $changed(buffer_a_input); endproperty
  a_mid: assert property (p_mid) else $error("no swap");
  property p_pulse; half_done |=> !half_done; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  property p_back;
    result_valid |-> ##[0:2] $changed(buffer_a_input);
  endproperty
  a_back: assert property (p_back) else $error("no swap back");
  property p_res; $changed(result) |-> result_valid; endproperty
  a_res: assert property (p_res) else $error("result moved");
  property p_end; result_valid |=> !converting; endproperty
  a_end: assert property (p_end) else $error("still on");
  property p_conv; converting |-> busy; endproperty
  a_conv: assert property (p_conv) else $error("busy");
  // one cycle of slack for the registered state change
  property p_settle;
    $rose(converting) && $past(busy) |-> gap >= SETTLE_COUNT - 1;
  endproperty
  a_settle: assert property (p_settle) else $error("settle");
  cover property (result_valid);
  cover property (half_done);
  cover property ($rose(converting) && $past(busy));
endmodule : azm_chk
bind autozero_mux_sequencer azm_chk #(.SETTLE_COUNT(SETTLE_COUNT)) chk (
  .ref_clk, .rst_n, .buffer_a_input, .buffer_b_input, .converting,
  .half_done, .result_valid, .result, .busy);

// *** verif/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  // serial clock stands high outside frames
  initial {sclk, cs_n, sdi} = 3'b110;
  // 32 falling edges, 13-bit word msb first, then filler
  task automatic frame(input logic [12:0] w);
    cs_n = 0;
    sdi = w[12];
    for (int i = 0; i < 32; i++) begin
      #32 sclk = 0;
      #32 sclk = 1;
      sdi = (i < 12) ? w[11-i] : ~sdi;
    end
    cs_n = 1;
    sdi = ~sdi; // released line does not keep its value
  endtask : frame
endmodule : host_model

// *** verif/tb_autozero_mux_sequencer.sv ***
`timescale 1ns/1ps
module tb_autozero_mux_sequencer;
  import autozero_pkg::*;
  logic ref_clk, rst_n, mod_bit, sclk, cs_n, sdi, converting;
  logic half_done, result_valid, busy;
  logic [CH_W-1:0] buffer_a_input, buffer_b_input, ch;
  logic [DATA_W-1:0] result;
  logic [31:0] s = 32'h055a_ea65;
  int n_fail, comparisons;
  autozero_mux_sequencer #(.SETTLE_COUNT(10)) dut (.ref_clk, .rst_n,
    .sclk, .cs_n, .sdi, .mod_bit, .buffer_a_input, .buffer_b_input,
    .converting, .half_done, .result_valid, .result, .busy);
  host_model host (.sclk, .cs_n, .sdi);
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs
  task automatic check(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // polled on the falling edge so registered flags have settled
  task automatic wait_hi(ref logic f);
    repeat (9000) if (f !== 1'b1) @(negedge ref_clk);
    if (f !== 1'b1) n_fail++; // a flag that never came is a failure
  endtask : wait_hi
  task automatic print_verdict();
    $display("fails %0d of %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end
  // constant modulator level is pure offset, so each result must be zero
  initial begin
    rst_n = 0;
    mod_bit = 0;
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1;
    for (int k = 0; k < 8; k++) begin
      s = xs(s);
      ch = s[2:0];
      @(posedge ref_clk) #1 mod_bit = s[9];
      // ratio 64 or 128 comes from s[4] in either mode; 2x is set on odd k
      host.frame({8'h00, s[4], k[0], ch});
      // every result is checked, none dropped at the 2x rate
      wait_hi(converting);
      check(buffer_a_input, ch);
      check(buffer_b_input, ch ^ 3'h1);
      wait_hi(half_done);
      repeat (3) @(negedge ref_clk);
      check(buffer_a_input, ch ^ 3'h1);
      wait_hi(result_valid);
      check(result, 0);
      repeat (3) @(negedge ref_clk);
      check(buffer_a_input, ch);
    end
    print_verdict();
  end
endmodule : tb_autozero_mux_sequencer
